//--- pch_top.sv
// Configuration header: identification, function class, bus command control
`default_nettype none
`include "pch_consts.svh"

// Operation
// - Decode the whole 256-byte configuration region
// - Every configuration access completes, even after reset
// - Writes without storage complete and are dropped
// - Reserved or unimplemented registers read as zero
// - Device-specific registers only at bytes 64-255
// - Lowest byte address holds least significant byte
// - First 16 bytes common, rest per layout byte
// - Registers read back the value in use
// - Maker code read-only, never all ones
// - Part code low nibble mirrors revision code
// - Header layout byte reads 00h, single function
// - Class bytes at offsets 0Bh, 0Ah, 09h
// - Display class; subclass 01h on first revision
// - Zero command stops all but configuration cycles
// - Stepping bit always one, writes ignored
// - Parity response bit resets clear, gates reaction
// - Palette snoop bit stops claiming DAC writes
// - Special cycle bit gates special cycle monitoring
// - Memory and I/O enables power up cleared

module pch_top
#(
   parameter logic [15:0] MAKER_CODE = 16'h5a5a, // Arbitrary value
   parameter logic [11:0] PART_CODE_HI = 12'h7e1, // Arbitrary value
   parameter logic [3:0] FIRST_REV_CODE = 4'h0
)
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // Configuration access port
   input wire pch_pkg::pch_cfg_req_t cfg_req_i,
   output pch_pkg::pch_cfg_rsp_t cfg_rsp_o,
   // Revision source
   input wire logic [7:0] secondary_display_controller_row_ofs_hi_i,
   // Decoded bus cycles from the target front end
   input wire logic mem_hit_i,
   input wire logic io_hit_i,
   input wire logic palette_write_i,
   input wire logic special_cycle_i,
   input wire logic parity_err_i,
   // Claims and gated events
   output logic mem_claim_o,
   output logic io_claim_o,
   output logic palette_claim_o,
   output logic special_cycle_seen_o,
   output logic parity_err_report_o,
   output pch_pkg::pch_enables_t enables_o
);

   // Parameter check
   if (MAKER_CODE == 16'hffff)
   begin : g_bad_maker
      $error("maker code must not be all ones");
   end

   // Reset release through two flip-flops
   logic rst_meta_n;
   logic rst_sync_n;

   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end
      else
      begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   logic [3:0] rev_code;
   logic [15:0] cmd;
   logic cmd_wr;
   pch_pkg::pch_enables_t en;
   pch_pkg::pch_cfg_rsp_t rsp;
   pch_pkg::pch_cfg_rsp_t next_rsp;

   assign rev_code = secondary_display_controller_row_ofs_hi_i[`PCH_REV_MSB:`PCH_REV_LSB];

   // Only the command dword has storage; all other writes are discarded
   assign cmd_wr = cfg_req_i.valid && cfg_req_i.write && (cfg_req_i.dw_index == `PCH_DW_CMD);

   pch_cmd_reg u_cmd
   (
      .mclk_i(mclk_i),
      .rst_n_i(rst_sync_n),
      .wr_i(cmd_wr),
      .wr_byte0_i(cfg_req_i.byte_en[0]),
      .wdata_i(cfg_req_i.wdata[7:0]),
      .cmd_o(cmd),
      .enables_o(en)
   );

   // Subclass differs on the first revision only
   function automatic logic [7:0] subclass(input logic [3:0] rev);
      logic [7:0] s;
      s = `PCH_SUBCLASS;
      if (rev == FIRST_REV_CODE)
      begin
         s = `PCH_SUBCLASS_FIRST;
      end
      return s;
   endfunction : subclass

   // Byte n of a dword sits in bits 8n+7:8n, offset order little-endian
   function automatic logic [31:0] read_word(input logic [5:0] idx, input logic [3:0] rev,
                                             input logic [15:0] cmd_val);
      logic [31:0] w;
      w = 32'h0000_0000;
      unique case (idx)
         `PCH_DW_ID:
         begin
            w = {PART_CODE_HI, rev, MAKER_CODE};
         end
         `PCH_DW_CMD:
         begin
            // Status half is outside this block and reads zero
            w = {16'h0000, cmd_val};
         end
         `PCH_DW_CLASS:
         begin
            w = {`PCH_BASECLASS, subclass(rev), `PCH_PROG_IF, 8'h00};
         end
         `PCH_DW_HDR:
         begin
            w = {8'h00, `PCH_HDR_TYPE, 16'h0000};
         end
         default:
         begin
            // Header tail and the device-specific area hold no storage
            w = 32'h0000_0000;
         end
      endcase
      return w;
   endfunction : read_word

   // Every request completes one cycle later, with no enable gating it
   always_comb
   begin
      next_rsp.done = cfg_req_i.valid;
      next_rsp.rdata = 32'h0000_0000;
      if (cfg_req_i.valid && !cfg_req_i.write)
      begin
         next_rsp.rdata = read_word(cfg_req_i.dw_index, rev_code, cmd);
      end
   end

   always_ff @(posedge mclk_i or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         rsp <= '0;
      end
      else
      begin
         rsp <= next_rsp;
      end
   end

   assign cfg_rsp_o = rsp;
   assign enables_o = en;

   // Non-configuration cycles are claimed only through the command enables
   assign mem_claim_o = mem_hit_i && en.mem_space;
   assign io_claim_o = io_hit_i && en.io_space;
   // Palette writes are I/O cycles; snooping drops only the write claim
   assign palette_claim_o = palette_write_i && en.io_space && !en.palette_snoop;
   assign special_cycle_seen_o = special_cycle_i && en.special_cycle;
   // Parity is still generated elsewhere; only the reaction is gated
   assign parity_err_report_o = parity_err_i && en.parity_resp;

   // Checks

   default clocking cb @(posedge mclk_i);
   endclocking

   default disable iff (!rst_sync_n);

   logic rd_req;
   assign rd_req = cfg_req_i.valid && !cfg_req_i.write;

   sequence cmd_zero_write_s;
      cfg_req_i.valid && cfg_req_i.write && (cfg_req_i.dw_index == `PCH_DW_CMD)
         && cfg_req_i.byte_en[0] && (cfg_req_i.wdata[7:0] == 8'h00);
   endsequence

   sequence all_claims_off_s;
      !mem_claim_o && !io_claim_o && !palette_claim_o && !special_cycle_seen_o
         && !parity_err_report_o;
   endsequence

   sequence cmd_write_s;
      cfg_req_i.valid && cfg_req_i.write && (cfg_req_i.dw_index == `PCH_DW_CMD)
         && cfg_req_i.byte_en[0];
   endsequence

   sequence cmd_read_s;
      rd_req && (cfg_req_i.dw_index == `PCH_DW_CMD);
   endsequence

   cfg_always_done_a: assert property (cfg_req_i.valid |=> rsp.done)
      else $error("configuration access not completed");

   no_spurious_done_a: assert property (!cfg_req_i.valid |=> !rsp.done)
      else $error("completion without a request");

   maker_read_a: assert property (
      (rd_req && cfg_req_i.dw_index == `PCH_DW_ID)
         |=> (rsp.rdata[15:0] == MAKER_CODE) && (rsp.rdata[15:0] != 16'hffff))
      else $error("maker code read wrong");

   part_rev_a: assert property (
      (rd_req && cfg_req_i.dw_index == `PCH_DW_ID)
         |=> rsp.rdata[19:16] == $past(secondary_display_controller_row_ofs_hi_i[7:4]))
      else $error("part code does not mirror revision");

   hdr_layout_a: assert property (
      (rd_req && cfg_req_i.dw_index == `PCH_DW_HDR) |=> rsp.rdata == 32'h0000_0000)
      else $error("header layout word not zero");

   class_code_a: assert property (
      (rd_req && cfg_req_i.dw_index == `PCH_DW_CLASS)
         |=> (rsp.rdata[31:24] == 8'h03) && (rsp.rdata[15:8] == 8'h00)
            && (rsp.rdata[23:16] == (($past(rev_code) == FIRST_REV_CODE) ? 8'h01 : 8'h00)))
      else $error("function class read wrong");

   reserved_zero_a: assert property (
      (rd_req && cfg_req_i.dw_index >= `PCH_COMMON_DW_END) |=> rsp.rdata == 32'h0000_0000)
      else $error("reserved location returned data");

   write_no_data_a: assert property (
      (cfg_req_i.valid && cfg_req_i.write) |=> rsp.done && (rsp.rdata == 32'h0000_0000))
      else $error("write completion carried data");

   ro_write_a: assert property (
      (cfg_req_i.valid && cfg_req_i.write && cfg_req_i.dw_index != `PCH_DW_CMD)
         |=> $stable(cmd))
      else $error("write to read-only location changed state");

   // A command write right after may legally re-enable, so it ends the window
   cmd_zero_stop_a: assert property (
      cmd_zero_write_s ##1 !cmd_wr |-> all_claims_off_s [*2])
      else $error("device still claims after zero command");

   cmd_readback_a: assert property (
      cmd_write_s ##1 cmd_read_s
         |=> rsp.rdata == {16'h0000, ($past(cfg_req_i.wdata[15:0], 2) & 16'h006b) | 16'h0080})
      else $error("command read back differs from written value");

   palette_snoop_a: assert property (
      (palette_write_i && en.palette_snoop) |-> !palette_claim_o)
      else $error("palette write claimed while snooping");

   special_gate_a: assert property (
      special_cycle_seen_o |-> (special_cycle_i && cmd[3]))
      else $error("special cycle seen while disabled");

   parity_gate_a: assert property (
      parity_err_i |-> (parity_err_report_o == cmd[6]))
      else $error("parity reaction not gated by command bit");

   enables_reset_a: assert property (disable iff (1'b0)
      (rst_sync_n && !$past(rst_sync_n)) |-> (cmd == 16'h0080) && !mem_claim_o && !io_claim_o)
      else $error("enables not cleared after reset");

   // The stepping bit is fixed, so every command read must show it set
   step_readback_a: assert property (
      cmd_read_s |=> rsp.rdata[`PCH_CMD_STEP] && (rsp.rdata[31:16] == 16'h0000))
      else $error("stepping bit not read back as one");

   id_high_a: assert property (
      (rd_req && cfg_req_i.dw_index == `PCH_DW_ID) |=> rsp.rdata[31:20] == PART_CODE_HI)
      else $error("part code high bits read wrong");

   // Stale read data must not linger into write or idle completions
   rdata_idle_a: assert property (
      !rd_req |=> rsp.rdata == 32'h0000_0000)
      else $error("completion data without a read");

   space_gate_a: assert property (
      (!cmd[`PCH_CMD_MEM] |-> !mem_claim_o) and (!cmd[`PCH_CMD_IO] |-> !io_claim_o))
      else $error("space access claimed while disabled");

   enables_mirror_a: assert property (
      enables_o == {cmd[`PCH_CMD_PARITY], cmd[`PCH_CMD_PALETTE], cmd[`PCH_CMD_SPECIAL],
         cmd[`PCH_CMD_MEM], cmd[`PCH_CMD_IO]})
      else $error("enables differ from command bits in use");

   special_off_a: assert property (
      !enables_o.special_cycle |-> !special_cycle_seen_o)
      else $error("special cycle passed while monitoring is off");

endmodule : pch_top

`default_nettype wire

//--- pch_consts.svh
// Offsets, field positions and fixed values of the configuration header
`ifndef PCH_CONSTS_SVH
`define PCH_CONSTS_SVH

// Region sizes in dword indices: 256 bytes total, 64-byte header, 16-byte common part
`define PCH_CFG_DW_LAST 6'h3f
`define PCH_HDR_DW_END 6'h10
`define PCH_COMMON_DW_END 6'h04

// Byte offsets of the implemented fields
`define PCH_OFS_MAKER 8'h00
`define PCH_OFS_PART 8'h02
`define PCH_OFS_CMD 8'h04
`define PCH_OFS_STATUS 8'h06
`define PCH_OFS_PROG_IF 8'h09
`define PCH_OFS_SUBCLASS 8'h0a
`define PCH_OFS_BASECLASS 8'h0b
`define PCH_OFS_HDR 8'h0e

// Dword indices that hold those fields
`define PCH_DW_ID 6'h00
`define PCH_DW_CMD 6'h01
`define PCH_DW_CLASS 6'h02
`define PCH_DW_HDR 6'h03

// Command field positions
`define PCH_CMD_IO 0
`define PCH_CMD_MEM 1
`define PCH_CMD_SPECIAL 3
`define PCH_CMD_PALETTE 5
`define PCH_CMD_PARITY 6
`define PCH_CMD_STEP 7

// Command reset value and mask of the writable bits
`define PCH_CMD_RESET 16'h0080
`define PCH_CMD_WMASK 16'h006b

// Class code and header layout values
`define PCH_BASECLASS 8'h03
`define PCH_SUBCLASS 8'h00
`define PCH_SUBCLASS_FIRST 8'h01
`define PCH_PROG_IF 8'h00
`define PCH_HDR_TYPE 8'h00

// Revision code position in the row offset high register
`define PCH_REV_MSB 7
`define PCH_REV_LSB 4

`endif

//--- pch_pkg.sv
// Types shared by the configuration header modules
`default_nettype none

package pch_pkg;

   // One configuration access, taken in the cycle that valid is high
   typedef struct packed {
      logic valid;
      logic write;
      logic [5:0] dw_index;
      logic [3:0] byte_en;
      logic [31:0] wdata;
   } pch_cfg_req_t;

   // Completion, one cycle after the request
   typedef struct packed {
      logic done;
      logic [31:0] rdata;
   } pch_cfg_rsp_t;

   // Response enables decoded from the bus command control word
   typedef struct packed {
      logic parity_resp;
      logic palette_snoop;
      logic special_cycle;
      logic mem_space;
      logic io_space;
   } pch_enables_t;

endpackage : pch_pkg

`default_nettype wire

//--- pch_cmd_reg.sv
// Bus command control word with fixed and writable bits
`default_nettype none
`include "pch_consts.svh"

module pch_cmd_reg
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Write port, low byte lane only
   input wire logic wr_i,
   input wire logic wr_byte0_i,
   input wire logic [7:0] wdata_i,
   // State
   output logic [15:0] cmd_o,
   output pch_pkg::pch_enables_t enables_o
);

   logic [15:0] cmd;
   logic [15:0] next_cmd;

   // Only byte 0 holds storage; byte 1 lane is fully reserved
   always_comb
   begin
      next_cmd = cmd;
      if (wr_i && wr_byte0_i)
      begin
         next_cmd = (`PCH_CMD_RESET & ~`PCH_CMD_WMASK) | ({8'h00, wdata_i} & `PCH_CMD_WMASK);
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cmd <= `PCH_CMD_RESET;
      end
      else
      begin
         cmd <= next_cmd;
      end
   end

   assign cmd_o = cmd;
   assign enables_o.parity_resp = cmd[`PCH_CMD_PARITY];
   assign enables_o.palette_snoop = cmd[`PCH_CMD_PALETTE];
   assign enables_o.special_cycle = cmd[`PCH_CMD_SPECIAL];
   assign enables_o.mem_space = cmd[`PCH_CMD_MEM];
   assign enables_o.io_space = cmd[`PCH_CMD_IO];

   step_fixed_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      cmd[`PCH_CMD_STEP] && ((cmd & ~`PCH_CMD_WMASK) == `PCH_CMD_RESET))
      else $error("command fixed bits changed");

   lane_ignored_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (wr_i && !wr_byte0_i) |=> $stable(cmd))
      else $error("command changed without its byte enable");

endmodule : pch_cmd_reg

`default_nettype wire

//--- pch_host_model.sv
// Host bridge model that issues configuration accesses
`default_nettype none

module pch_host_model
(
   // Clock
   input wire logic mclk_i,
   // Configuration access port
   output pch_pkg::pch_cfg_req_t req_o,
   input wire pch_pkg::pch_cfg_rsp_t rsp_i
);
   timeunit 1ns;
   timeprecision 1ps;

   initial req_o = '0;

   // Entered at a falling edge; the request stands across the taking edge
   task automatic access(input logic wr, input logic [5:0] idx, input logic [3:0] be,
      input logic [31:0] wd, output logic done, output logic [31:0] rd);
      req_o = '{valid: 1'b1, write: wr, dw_index: idx, byte_en: be, wdata: wd};
      @(posedge mclk_i);
      @(negedge mclk_i);
      done = rsp_i.done;
      rd = rsp_i.rdata;
   endtask : access

   // Released qualifiers toggle so that nothing leans on their old value
   task automatic idle();
      req_o = '{valid: 1'b0, write: ~req_o.write, dw_index: ~req_o.dw_index,
         byte_en: ~req_o.byte_en, wdata: ~req_o.wdata};
      @(posedge mclk_i);
      @(negedge mclk_i);
   endtask : idle

   // An empty slot ends in a master-abort and reads as all ones
   task automatic probe(input logic present, input logic [5:0] idx, output logic [31:0] rd);
      logic done;
      if (present)
         access(1'b0, idx, 4'hf, 32'h0, done, rd);
      else
         rd = 32'hffff_ffff;
   endtask : probe

   // Bits outside the mask are written back exactly as read
   task automatic rmw(input logic [5:0] idx, input logic [31:0] mask, input logic [31:0] val);
      logic done;
      logic [31:0] old;
      access(1'b0, idx, 4'hf, 32'h0, done, old);
      access(1'b1, idx, 4'hf, (old & ~mask) | (val & mask), done, old);
   endtask : rmw
endmodule : pch_host_model

`default_nettype wire

//--- pci_config_header_tb_top.sv
// Self-checking bench of the configuration header
`default_nettype none

module pci_config_header_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [15:0] MAKER = 16'h3c3c; // Arbitrary value
   localparam logic [11:0] PART_HI = 12'h5a1; // Arbitrary value
   localparam logic [3:0] FIRST_REV = 4'h2;

   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] row_hi = 8'h00;
   logic [4:0] hits = 5'h00;
   logic [4:0] claims;
   logic [15:0] lfsr = 16'h0043;
   pch_pkg::pch_cfg_req_t req;
   pch_pkg::pch_cfg_rsp_t rsp;
   pch_pkg::pch_enables_t ens;
   int fails = 0;
   int n_compared = 0;
   int cycles = 0;
   int cmd = 'h80;

   always #2.5 mclk = ~mclk;

   pch_top #(.MAKER_CODE(MAKER), .PART_CODE_HI(PART_HI), .FIRST_REV_CODE(FIRST_REV)) u_dut (
      .mclk_i(mclk), .nrst_i(rst_n), .cfg_req_i(req), .cfg_rsp_o(rsp),
      .secondary_display_controller_row_ofs_hi_i(row_hi),
      .mem_hit_i(hits[4]), .io_hit_i(hits[3]), .palette_write_i(hits[2]),
      .special_cycle_i(hits[1]), .parity_err_i(hits[0]),
      .mem_claim_o(claims[4]), .io_claim_o(claims[3]), .palette_claim_o(claims[2]),
      .special_cycle_seen_o(claims[1]), .parity_err_report_o(claims[0]), .enables_o(ens));

   pch_host_model u_host (.mclk_i(mclk), .req_o(req), .rsp_i(rsp));

   function automatic logic [31:0] rnd();
      logic [31:0] v;
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      v[15:0] = lfsr;
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      v[31:16] = lfsr;
      return v;
   endfunction : rnd

   function automatic logic [31:0] exp_dw(input int idx, input logic [3:0] rev);
      case (idx)
         0: return {PART_HI, rev, MAKER};
         1: return {16'h0000, cmd[15:0]};
         2: return {8'h03, (rev == FIRST_REV) ? 8'h01 : 8'h00, 16'h0000};
         default: return 32'h0000_0000;
      endcase
   endfunction : exp_dw

   task automatic chk_data(input string what, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask : chk_data

   task automatic chk_flags(input logic [9:0] e, input logic [9:0] g);
      n_compared++;
      if (g !== e)
      begin
         fails++;
         $display("[FAIL] claims and enables expected %h seen %h", e, g);
      end
   endtask : chk_flags

   // Entered and left at a falling edge with the request released
   task automatic check_gate();
      logic [31:0] v;
      v = rnd();
      hits = v[4:0];
      u_host.idle();
      chk_flags({hits[4] & cmd[1], hits[3] & cmd[0], hits[2] & cmd[0] & ~cmd[5],
         hits[1] & cmd[3], hits[0] & cmd[6], cmd[6], cmd[5], cmd[3], cmd[1], cmd[0]},
         {claims, ens});
   endtask : check_gate

   task automatic cfg(input logic wr, input logic [5:0] idx, input logic [3:0] be,
      input logic [31:0] wd, output logic [31:0] rd);
      logic done;
      u_host.access(wr, idx, be, wd, done, rd);
      chk_data("done", 32'h1, {31'h0, done});
      if (wr)
         chk_data("write rdata", 32'h0, rd);
      if (wr && idx == 6'h01 && be[0])
         cmd = (wd[7:0] & 8'h6b) | 8'h80;
   endtask : cfg

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : print_verdict

   // Whole run needs about 720 cycles
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         fails++;
         print_verdict();
      end
   end

   initial
   begin
      logic [31:0] v;
      logic [31:0] w;
      logic [31:0] rd;
      logic [5:0] idx;
      repeat (8) @(negedge mclk);
      check_gate();
      rst_n = 1'b1;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      // Back to back over the region, starting at the first legal edge
      for (int i = 0; i < 64; i++)
      begin
         v = rnd();
         row_hi = v[7:0];
         cfg(1'b0, i[5:0], 4'hf, v, rd);
         chk_data("read", exp_dw(i, row_hi[7:4]), rd);
      end
      for (int r = 0; r < 32; r++)
      begin
         v = rnd();
         row_hi = {r[3:0], v[3:0]};
         idx = r[4] ? 6'h02 : 6'h00;
         cfg(1'b0, idx, 4'hf, v, rd);
         chk_data("ident", exp_dw(idx, r[3:0]), rd);
      end
      for (int i = 0; i < 200; i++)
      begin
         v = rnd();
         w = rnd();
         idx = v[31] ? 6'h01 : v[29:24];
         if (i < 2)
         begin
            w = {32{i[0]}};
            idx = 6'h01;
            v[20] = 1'b1;
         end
         cfg(1'b1, idx, v[23:20], w, rd);
         cfg(1'b0, 6'h01, 4'hf, v, rd);
         chk_data("command", exp_dw(1, 4'h0), rd);
         check_gate();
      end
      u_host.rmw(6'h01, 32'h0000_0022, 32'hffff_ffff);
      cmd = ((cmd & 'hdd) | 'h22) & 'hff;
      cfg(1'b0, 6'h01, 4'hf, 32'h0, rd);
      chk_data("merged command", exp_dw(1, 4'h0), rd);
      check_gate();
      u_host.probe(1'b0, 6'h00, rd);
      chk_data("empty slot", 32'hffff_ffff, rd);
      // Mid-run reset must drop an enabled command back to its power-up value
      rst_n = 1'b0;
      cmd = 'h80;
      check_gate();
      check_gate();
      rst_n = 1'b1;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      cfg(1'b0, 6'h01, 4'hf, 32'h0, rd);
      chk_data("command after reset", exp_dw(1, 4'h0), rd);
      check_gate();
      print_verdict();
   end
endmodule : pci_config_header_tb_top

`default_nettype wire
